// ==== logic/dtcs_event_if.sv ====
// events and control of one timer between top and timer core
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface dtcs_event_if;
  logic [1:0] mode;
  logic [2:0] prescale;
  logic cap_edge_sel;
  logic evt_edge_sel;
  logic [15:0] compare_value_one;
  logic [15:0] compare_value_two;
  logic cap1_ev;
  logic cap2_ev;
  logic match1_ev;
  logic match2_ev;
  logic wrap_ev;
  logic [15:0] count;
  modport ctl (output mode, prescale, cap_edge_sel, evt_edge_sel, compare_value_one,
    compare_value_two, input cap1_ev, cap2_ev, match1_ev, match2_ev, wrap_ev, count);
  modport core (input mode, prescale, cap_edge_sel, evt_edge_sel, compare_value_one,
    compare_value_two, output cap1_ev, cap2_ev, match1_ev, match2_ev, wrap_ev, count);
endinterface
`default_nettype wire

// ==== logic/dtcs_params.svh ====
// constants of the dual timer control and status block
// assumes a 32-bit apb register bus and one system clock
`ifndef DTCS_PARAMS_SVH
`define DTCS_PARAMS_SVH
// ==========================================
// register byte offsets
`define DTCS_T1_CTLA_OFF 12'h000
`define DTCS_T1_CTLB_OFF 12'h004
`define DTCS_T2_CTLA_OFF 12'h008
`define DTCS_T2_CTLB_OFF 12'h00C
`define DTCS_T1_CNT_OFF 12'h010
`define DTCS_T2_CNT_OFF 12'h014
`define DTCS_IRQ_STAT_OFF 12'h018
`define DTCS_IRQ_MASK_OFF 12'h01C
// ==========================================
// control a field positions
`define DTCS_A_CPF2 7
`define DTCS_A_CPF1 6
`define DTCS_A_CPIE 5
`define DTCS_A_CMF2 4
`define DTCS_A_CMF1 3
`define DTCS_A_CMIE 2
`define DTCS_A_OVF 1
`define DTCS_A_OVIE 0
// ==========================================
// control b field positions
`define DTCS_B_TOP 7
`define DTCS_B_CPEDG 6
`define DTCS_B_EXEDG 5
`define DTCS_B_PS_HI 4
`define DTCS_B_PS_LO 2
`define DTCS_B_MC_HI 1
`define DTCS_B_MC_LO 0
// ==========================================
// reset and maximum values
`define DTCS_CTLA_RST 8'h00
`define DTCS_CTLB_RST 8'h00
`define DTCS_CNT_RST 16'h0000
`define DTCS_CNT_MAX 16'hFFFF
`define DTCS_RTC_MAX 8'hFF
`endif

// ==== logic/dtcs_pkg.sv ====
// types of the dual timer control and status block
// assumes nothing of its surroundings
package dtcs_pkg;
  typedef enum logic [1:0] {
    DTCS_SW_TIMER = 2'h0,
    DTCS_PWM = 2'h1,
    DTCS_CAP_CMP = 2'h2,
    DTCS_EXT_EVENT = 2'h3
  } dtcs_mode_t;
  typedef enum logic [1:0] {
    DTCS_IDLE,
    DTCS_SETUP,
    DTCS_ACCESS
  } dtcs_apb_state_t;
endpackage

// ==== logic/dtcs_timer_core.sv ====
// one 16-bit timer counter with prescaler, capture edges and match
// assumes pins synchronous to core_clk_in
`timescale 1ns/100ps
`default_nettype none
`include "dtcs_params.svh"
module dtcs_timer_core (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic cap1_pin_in,
  input wire logic cap2_pin_in,
  input wire logic evt_pin_in,
  dtcs_event_if.core ev
);
  logic [6:0] pre_q;
  logic [2:0] pre_sel_q;
  logic [15:0] cnt_q;
  logic cap1_q, cap2_q, evt_q, phase_q;
  logic [6:0] pre_lim;
  logic pre_tick, tick, ext_mode, cap_mode;
  logic cap1_edge, cap2_edge, evt_edge;
  logic [15:0] active_cmp;
  logic hit, wrap;
  // ==========================================
  // prescaler and edge detect
  assign pre_lim = 7'((8'h01 << ev.prescale) - 8'h01);
  assign pre_tick = (pre_q >= pre_lim); // see [R10]
  assign ext_mode = (ev.mode == dtcs_pkg::DTCS_EXT_EVENT); // see [R12]
  assign cap_mode = (ev.mode == dtcs_pkg::DTCS_CAP_CMP); // see [R12]
  assign cap1_edge = ev.cap_edge_sel ? (cap1_pin_in & ~cap1_q) : (~cap1_pin_in & cap1_q); // see [R8]
  assign cap2_edge = ev.cap_edge_sel ? (cap2_pin_in & ~cap2_q) : (~cap2_pin_in & cap2_q); // see [R8]
  assign evt_edge = ev.evt_edge_sel ? (evt_pin_in & ~evt_q) : (~evt_pin_in & evt_q); // see [R9]
  assign tick = ext_mode ? evt_edge : pre_tick; // see [R11]
  assign active_cmp = phase_q ? ev.compare_value_two : ev.compare_value_one;
  assign hit = tick & (cnt_q == (cap_mode ? ev.compare_value_one : active_cmp));
  assign wrap = tick & (cnt_q == `DTCS_CNT_MAX); // see [R14]
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pre_q <= 7'h00;
      pre_sel_q <= 3'h0;
      cap1_q <= 1'b0;
      cap2_q <= 1'b0;
      evt_q <= 1'b0;
    end else begin
      pre_sel_q <= ev.prescale;
      pre_q <= (pre_tick || pre_sel_q != ev.prescale) ? 7'h00 : pre_q + 7'h01;
      cap1_q <= cap1_pin_in;
      cap2_q <= cap2_pin_in;
      evt_q <= evt_pin_in;
    end
  end
  // ==========================================
  // counter
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_q <= `DTCS_CNT_RST;
      phase_q <= 1'b0;
    end else if (hit && !cap_mode) begin
      cnt_q <= `DTCS_CNT_RST;
      phase_q <= ~phase_q;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001; // see [R11]
    end
  end
  assign ev.count = cnt_q;
  assign ev.match1_ev = hit & (cap_mode | ~phase_q); // see [R15]
  assign ev.match2_ev = hit & ~cap_mode & phase_q; // see [R15]
  assign ev.wrap_ev = wrap;
  assign ev.cap1_ev = cap_mode & cap1_edge;
  assign ev.cap2_ev = cap_mode & cap2_edge; // see [R1]
  a_prescale_period: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (pre_sel_q == 3'h2 && ev.prescale == 3'h2) |=>
      (pre_q == (($past(pre_q) == 7'h03) ? 7'h00 : $past(pre_q) + 7'h01)))
    else $error("prescale period wrong"); // see [R11]
endmodule
`default_nettype wire

// ==== logic/dtcs_top.sv ====
// apb register file, flags and interrupts of two 16-bit timers
// assumes apb master on core_clk_in; pins synchronous to the clock
// Operation
// [R1] capture pin two edge in capture mode sets a sticky capture-two flag
// [R2] event flags in control a stay set until software clears them
// [R3] control a holds enables and flags for match, capture and wrap
// [R4] wrap interrupt enable gates wrap interrupts on or off
// [R5] bit 7 of timer one control b flags the 8-bit realtime counter wrap
// [R6] realtime counter wrap flag stays set until software clears it
// [R7] each control b has one configuration bit unrelated to the timers; only timer two bit 7 drives port_cfg_out, bit 0 is tied to zero
// [R8] capture edge select picks rising when one, falling when zero
// [R9] event edge select picks rising when one, falling when zero
// [R10] 3-bit prescale code n divides system clock by two to the n
// [R11] counter advances once per prescaler period
// [R12] 2-bit mode field selects timer, pwm, capture/compare, event count
// [R13] timer two has an identical control a layout
// [R14] wrap from maximum to zero sets the wrap flag and may interrupt
// [R15] separate flags for match one, match two and wrap
// [R16] timer interrupt is high while any flag and its enable are set
// [R17] writing zero clears a flag, one keeps it; hardware set wins
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "dtcs_params.svh"
module dtcs_top (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] cap1_pin_in,
  input wire logic [1:0] cap2_pin_in,
  input wire logic [1:0] evt_pin_in,
  input wire logic rtc_tick_in,
  input wire logic [15:0] t1_compare_one_in,
  input wire logic [15:0] t1_compare_two_in,
  input wire logic [15:0] t2_compare_one_in,
  input wire logic [15:0] t2_compare_two_in,
  output logic [1:0] timer_irq_out,
  output logic [1:0] port_cfg_out,
  output logic irq_out
);
  dtcs_event_if tev[2] ();
  logic [7:0] ctla_q [2];
  logic [7:0] ctlb_q [2];
  logic [7:0] realtime_byte_counter_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_stat_q;
  logic [2:0] irq_src;
  logic apb_wr, apb_rd_ok, rtc_wrap;
  logic sel_t1a, sel_t1b, sel_t2a, sel_t2b, sel_c1, sel_c2, sel_st, sel_mk;
  logic [15:0] t_count [2];
  logic [15:0] cmp_one [2];
  logic [15:0] cmp_two [2];
  logic [31:0] rd_mux;
  // ==========================================
  // apb decode
  assign apb_wr = psel & penable & pwrite;
  assign sel_t1a = (paddr == `DTCS_T1_CTLA_OFF);
  assign sel_t1b = (paddr == `DTCS_T1_CTLB_OFF);
  assign sel_t2a = (paddr == `DTCS_T2_CTLA_OFF);
  assign sel_t2b = (paddr == `DTCS_T2_CTLB_OFF);
  assign sel_c1 = (paddr == `DTCS_T1_CNT_OFF);
  assign sel_c2 = (paddr == `DTCS_T2_CNT_OFF);
  assign sel_st = (paddr == `DTCS_IRQ_STAT_OFF);
  assign sel_mk = (paddr == `DTCS_IRQ_MASK_OFF);
  assign apb_rd_ok = sel_t1a | sel_t1b | sel_t2a | sel_t2b | sel_c1 | sel_c2 | sel_st | sel_mk;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~apb_rd_ok;
  assign rd_mux = sel_t1a ? {24'h000000, ctla_q[0]} :
                  sel_t1b ? {24'h000000, ctlb_q[0]} :
                  sel_t2a ? {24'h000000, ctla_q[1]} :
                  sel_t2b ? {24'h000000, ctlb_q[1]} :
                  sel_c1 ? {16'h0000, t_count[0]} :
                  sel_c2 ? {16'h0000, t_count[1]} :
                  sel_st ? {29'h00000000, irq_stat_q} :
                  sel_mk ? {29'h00000000, irq_mask_q} : 32'h00000000;
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end
  assign cmp_one[0] = t1_compare_one_in;
  assign cmp_one[1] = t2_compare_one_in;
  assign cmp_two[0] = t1_compare_two_in;
  assign cmp_two[1] = t2_compare_two_in;
  // ==========================================
  // per-timer control a and b
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_tmr
      logic [7:0] wd;
      logic wr_a, wr_b;
      logic [7:0] hw_set;
      logic [7:0] flag_d;
      logic [7:0] ctla_d;
      assign wd = pwdata[7:0];
      assign wr_a = apb_wr & (g == 0 ? sel_t1a : sel_t2a); // see [R13]
      assign wr_b = apb_wr & (g == 0 ? sel_t1b : sel_t2b);
      assign hw_set = {tev[g].cap2_ev, tev[g].cap1_ev, 1'b0, tev[g].match2_ev,
                       tev[g].match1_ev, 1'b0, tev[g].wrap_ev, 1'b0}; // see [R1] see [R14] see [R15]
      // flags: write zero clears, one keeps, set wins
      assign flag_d = (wr_a ? (ctla_q[g] & wd) : ctla_q[g]) | hw_set; // see [R2] see [R17]
      assign ctla_d = wr_a ? {flag_d[7:6], wd[5], flag_d[4:3], wd[2], flag_d[1], wd[0]}
                           : {flag_d[7:6], ctla_q[g][5], flag_d[4:3], ctla_q[g][2],
                              flag_d[1], ctla_q[g][0]}; // see [R3]
      always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
          ctla_q[g] <= `DTCS_CTLA_RST;
        end else begin
          ctla_q[g] <= ctla_d;
        end
      end
      if (g == 0) begin : g_b1
        logic top_d;
        // bit 7 of timer one control b is the realtime wrap flag
        assign top_d = (wr_b ? (ctlb_q[0][`DTCS_B_TOP] & wd[7]) : ctlb_q[0][`DTCS_B_TOP])
                       | rtc_wrap; // see [R5] see [R6]
        always_ff @(posedge core_clk_in or posedge reset_in) begin
          if (reset_in) begin
            ctlb_q[0] <= `DTCS_CTLB_RST;
          end else begin
            ctlb_q[0] <= {top_d, wr_b ? wd[6:0] : ctlb_q[0][6:0]};
          end
        end
      end else begin : g_b2
        always_ff @(posedge core_clk_in or posedge reset_in) begin
          if (reset_in) begin
            ctlb_q[1] <= `DTCS_CTLB_RST;
          end else if (wr_b) begin
            ctlb_q[1] <= wd;
          end
        end
      end
      assign tev[g].mode = ctlb_q[g][`DTCS_B_MC_HI:`DTCS_B_MC_LO]; // see [R12]
      assign tev[g].prescale = ctlb_q[g][`DTCS_B_PS_HI:`DTCS_B_PS_LO]; // see [R10]
      assign tev[g].cap_edge_sel = ctlb_q[g][`DTCS_B_CPEDG]; // see [R8]
      assign tev[g].evt_edge_sel = ctlb_q[g][`DTCS_B_EXEDG]; // see [R9]
      assign tev[g].compare_value_one = cmp_one[g];
      assign tev[g].compare_value_two = cmp_two[g];
      assign t_count[g] = tev[g].count;
      // interrupt request per timer
      assign timer_irq_out[g] = (ctla_q[g][`DTCS_A_CPIE] & (ctla_q[g][7] | ctla_q[g][6]))
        | (ctla_q[g][`DTCS_A_CMIE] & (ctla_q[g][4] | ctla_q[g][3]))
        | (ctla_q[g][`DTCS_A_OVIE] & ctla_q[g][`DTCS_A_OVF]); // see [R16] see [R4]
      dtcs_timer_core u_core (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .cap1_pin_in(cap1_pin_in[g]),
        .cap2_pin_in(cap2_pin_in[g]),
        .evt_pin_in(evt_pin_in[g]),
        .ev(tev[g])
      );
      a_wrap_flag_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
        tev[g].wrap_ev |=> ctla_q[g][`DTCS_A_OVF]) else $error("wrap flag not set"); // see [R14]
      a_flag_sticky: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (ctla_q[g][`DTCS_A_CPF2] && !wr_a) |=> ctla_q[g][`DTCS_A_CPF2])
        else $error("capture flag dropped"); // see [R2]
      a_cap2_flag_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
        tev[g].cap2_ev |=> ctla_q[g][`DTCS_A_CPF2]) else $error("capture two lost"); // see [R1]
      a_clear_on_zero: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (wr_a && !wd[`DTCS_A_CMF1] && !tev[g].match1_ev) |=> !ctla_q[g][`DTCS_A_CMF1])
        else $error("zero write did not clear"); // see [R17]
      a_wrap_irq_gate: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (ctla_q[g][1:0] == 2'h2 && ctla_q[g][7:2] == 6'h00) |-> !timer_irq_out[g])
        else $error("masked wrap raised irq"); // see [R4]
      a_irq_follows: assert property (@(posedge core_clk_in) disable iff (reset_in)
        (ctla_q[g][1:0] == 2'h3) |-> timer_irq_out[g]) else $error("wrap irq missing"); // see [R16]
    end
  endgenerate
  // ==========================================
  // realtime byte counter
  assign rtc_wrap = rtc_tick_in & (realtime_byte_counter_q == `DTCS_RTC_MAX);
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      realtime_byte_counter_q <= 8'h00;
    end else if (rtc_tick_in) begin
      realtime_byte_counter_q <= realtime_byte_counter_q + 8'h01;
    end
  end
  assign port_cfg_out = {ctlb_q[1][`DTCS_B_TOP], 1'b0}; // see [R7]
  a_rtc_flag_set: assert property (@(posedge core_clk_in) disable iff (reset_in)
    rtc_wrap |=> ctlb_q[0][`DTCS_B_TOP]) else $error("realtime wrap flag lost"); // see [R5]
  a_rtc_sticky: assert property (@(posedge core_clk_in) disable iff (reset_in)
    (ctlb_q[0][7] && !(apb_wr && sel_t1b)) |=> ctlb_q[0][7]) else $error("rt flag dropped"); // see [R6]
  // ==========================================
  // block interrupt: status, mask, write one to clear
  assign irq_src = {rtc_wrap, timer_irq_out[1], timer_irq_out[0]};
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((apb_wr && sel_st) ? pwdata[2:0] : 3'h0)) | irq_src;
      if (apb_wr && sel_mk) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end
  assign irq_out = |(irq_stat_q & irq_mask_q);
endmodule
`default_nettype wire

// ==== verification/tb_dtcs_top.sv ====
// self-checking bench of the dual timer control and status top
// assumes the design files under logic/ and one 25 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "dtcs_params.svh"
module tb_dtcs_top;
  typedef struct {logic [31:0] val; logic [31:0] mask;} dtcs_note_t;
  // ==========================================
  // signals and design
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] cap1_pin_in = 2'h0;
  logic [1:0] cap2_pin_in = 2'h0;
  logic [1:0] evt_pin_in = 2'h0;
  logic rtc_tick_in = 1'b0;
  logic [15:0] c1a = 16'h8000;
  logic [15:0] c1b = 16'h8000;
  logic [15:0] c2a = 16'h8000;
  logic [15:0] c2b = 16'h8000;
  logic [1:0] timer_irq_out;
  logic [1:0] port_cfg_out;
  logic irq_out;
  int fails = 0;
  int checks = 0;
  integer seed = 17;
  logic [31:0] rd_val;
  logic rd_err;
  logic [31:0] cnt_a;
  logic [7:0] v;
  dtcs_note_t exp_q[$];
  always #20 core_clk_in = ~core_clk_in;
  dtcs_top i_dtcs_top (.core_clk_in(core_clk_in), .reset_in(reset_in), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cap1_pin_in(cap1_pin_in), .cap2_pin_in(cap2_pin_in),
    .evt_pin_in(evt_pin_in), .rtc_tick_in(rtc_tick_in), .t1_compare_one_in(c1a),
    .t1_compare_two_in(c1b), .t2_compare_one_in(c2a), .t2_compare_two_in(c2b),
    .timer_irq_out(timer_irq_out), .port_cfg_out(port_cfg_out), .irq_out(irq_out));
  // ==========================================
  // tasks
  task automatic cmp_sig(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
    @(posedge core_clk_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do @(posedge core_clk_in); while (pready !== 1'b1);
    rd_val = prdata;
    rd_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] addr, input logic [31:0] exp, input logic [31:0] mask);
    exp_q.push_back('{exp, mask});
    apb(1'b0, addr, 32'h0);
  endtask
  task automatic wr(input logic [11:0] addr, input logic [31:0] data);
    apb(1'b1, addr, data);
  endtask
  task automatic settle;
    @(negedge core_clk_in);
  endtask
  task automatic pin_wait;
    repeat (4) @(posedge core_clk_in);
  endtask
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // read data monitor
  always @(posedge core_clk_in) begin
    dtcs_note_t n;
    if (psel && penable && !pwrite && pready) begin
      n = exp_q.pop_front();
      if (n.mask != 32'h0)
        cmp_sig("prdata", prdata & n.mask, n.val & n.mask);
    end
  end
  initial begin
    #(90000 * 40);
    fails++;
    end_sim();
  end
  // ==========================================
  // scenarios
  initial begin
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    c1a <= 16'h8000 | 16'($random(seed));
    c2a <= 16'h8000 | 16'($random(seed));
    for (int a = 0; a < 8; a++)
      rd(12'(a * 4), 32'h0, (a == 4 || a == 5) ? 32'h0 : 32'hFFFF_FFFF);
    rd(12'h020, 32'h0, 32'hFFFF_FFFF);
    cmp_sig("pslverr", 32'(rd_err), 32'h1);
    wr(`DTCS_T1_CTLA_OFF, 32'hFF);
    rd(`DTCS_T1_CTLA_OFF, 32'h25, 32'hFF);
    wr(`DTCS_T2_CTLA_OFF, 32'hFF);
    rd(`DTCS_T2_CTLA_OFF, 32'h25, 32'hFF);
    wr(`DTCS_T1_CTLA_OFF, 32'h0);
    wr(`DTCS_T2_CTLA_OFF, 32'h0);
    for (int i = 0; i < 256; i++) begin
      if (i == 255)
        rd(`DTCS_T1_CTLB_OFF, 32'h0, 32'h80);
      @(posedge core_clk_in);
      rtc_tick_in <= 1'b1;
      @(posedge core_clk_in);
      rtc_tick_in <= 1'b0;
    end
    pin_wait();
    rd(`DTCS_T1_CTLB_OFF, 32'h80, 32'h80);
    wr(`DTCS_T1_CTLB_OFF, 32'h80);
    rd(`DTCS_T1_CTLB_OFF, 32'h80, 32'h80);
    wr(`DTCS_T1_CTLB_OFF, 32'h0);
    rd(`DTCS_T1_CTLB_OFF, 32'h0, 32'h80);
    for (int m = 0; m < 4; m++) begin
      v = {8'($random(seed)) & 8'hFC} | 8'(m);
      evt_pin_in <= 2'($random(seed));
      wr(`DTCS_T2_CTLB_OFF, 32'(v));
      rd(`DTCS_T2_CTLB_OFF, 32'(v), 32'hFF);
      cmp_sig("port_cfg", 32'(port_cfg_out), {30'h0, v[7], 1'b0});
      wr(`DTCS_T1_CTLB_OFF, 32'(v));
      rd(`DTCS_T1_CTLB_OFF, 32'(v & 8'h7F), 32'hFF);
    end
    for (int n = 0; n < 8; n++) begin
      wr(`DTCS_T1_CTLB_OFF, 32'((n << 2) | 2));
      rd(`DTCS_T1_CNT_OFF, 32'h0, 32'h0);
      cnt_a = rd_val;
      repeat (1021) @(posedge core_clk_in);
      rd(`DTCS_T1_CNT_OFF, 32'h0, 32'h0);
      cmp_sig("count_step", (rd_val - cnt_a) & 32'hFFFF, 32'(1024 >> n));
    end
    for (int e = 1; e >= 0; e--) begin
      wr(`DTCS_T1_CTLB_OFF, 32'((e << 6) | 2));
      cap2_pin_in[0] <= 1'(e);
      pin_wait();
      wr(`DTCS_T1_CTLA_OFF, 32'h0);
      cap2_pin_in[0] <= 1'(~e);
      pin_wait();
      rd(`DTCS_T1_CTLA_OFF, 32'h0, 32'h80);
      cap2_pin_in[0] <= 1'(e);
      pin_wait();
      rd(`DTCS_T1_CTLA_OFF, 32'h80, 32'h80);
    end
    wr(`DTCS_T1_CTLA_OFF, 32'h0);
    wr(`DTCS_T2_CTLB_OFF, 32'h42);
    wr(`DTCS_T2_CTLA_OFF, 32'h20);
    cap1_pin_in[1] <= 1'b1;
    pin_wait();
    rd(`DTCS_T2_CTLA_OFF, 32'h60, 32'h60);
    cmp_sig("timer_irq", 32'(timer_irq_out), 32'h2);
    wr(`DTCS_IRQ_MASK_OFF, 32'h2);
    settle();
    cmp_sig("irq", 32'(irq_out), 32'h1);
    wr(`DTCS_IRQ_MASK_OFF, 32'h0);
    settle();
    cmp_sig("irq", 32'(irq_out), 32'h0);
    wr(`DTCS_IRQ_MASK_OFF, 32'h2);
    wr(`DTCS_T2_CTLA_OFF, 32'h20);
    settle();
    cmp_sig("timer_irq", 32'(timer_irq_out), 32'h0);
    rd(`DTCS_IRQ_STAT_OFF, 32'h2, 32'h2);
    wr(`DTCS_IRQ_STAT_OFF, 32'h7);
    settle();
    cmp_sig("irq", 32'(irq_out), 32'h0);
    wr(`DTCS_T1_CTLB_OFF, 32'h2);
    wr(`DTCS_T1_CTLA_OFF, 32'h1);
    repeat (66000) @(posedge core_clk_in);
    cmp_sig("timer_irq", 32'(timer_irq_out[0]), 32'h1);
    wr(`DTCS_T1_CTLA_OFF, 32'h02);
    settle();
    cmp_sig("timer_irq", 32'(timer_irq_out[0]), 32'h0);
    rd(`DTCS_T1_CTLA_OFF, 32'h02, 32'h03);
    wr(`DTCS_T1_CTLA_OFF, 32'h0);
    rd(`DTCS_T1_CTLA_OFF, 32'h0, 32'h02);
    end_sim();
  end
endmodule
`default_nettype wire
